// ==== src/vmc_map.vh ====
// register map, codes and reset values of the virtualization enter/leave checker
// What this block does
// RL1 - leave faults invalid-opcode on bad mode
// RL2 - enter faults invalid-opcode on bad mode/operand
// RL3 - enter or leave as guest exits
// RL4 - leave at nonzero privilege: protection fault
// RL5 - leave under dual monitor fails, stays
// RL6 - leave success: exit, unblock init, clear
// RL7 - leave unblocks interrupts only if ctl[2]=0
// RL8 - leave re-enables a20 mask outside safer mode
// RL9 - enter takes 64-bit memory region address
// RL10 - enter outside operation: protection fault checks
// RL11 - unaligned or too-wide region address fails
// RL12 - capability 48 set: high bits fail
// RL13 - bad revision word or bit31 fails
// RL14 - enter success: pointer ones, block, disable
// RL15 - enter in monitor operation fails valid
// RL16 - leave and write fault invalid-opcode outside operation
// RL17 - bad data segment operand: protection fault
// RL18 - bad stack segment: stack fault; page faults
// RL19 - non-canonical 64-bit address: stack/protection fault
// RL20 - error numbers 15 and 23 loaded
// RL21 - strict priority, one outcome per instruction
`ifndef VMC_MAP_VH
`define VMC_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define VMC_OFF_CTRL    8'h00
`define VMC_OFF_FEAT    8'h04
`define VMC_OFF_MONCTL  8'h08
`define VMC_OFF_CAP     8'h0c
`define VMC_OFF_REV     8'h10
`define VMC_OFF_STATUS  8'h14
`define VMC_OFF_PTR_LO  8'h18
`define VMC_OFF_PTR_HI  8'h1c
`define VMC_OFF_RGN_LO  8'h20
`define VMC_OFF_RGN_HI  8'h24

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define VMC_FEAT_LOCK      0
`define VMC_FEAT_EN_SAFER  1
`define VMC_FEAT_EN_PLAIN  2
`define VMC_MONCTL_KEEP    2
`define VMC_CAP_NARROW     16
`define VMC_CTRL_SMI_SET   0
`define VMC_FEAT_RST       3'h0
`define VMC_MONCTL_RST     3'h0
`define VMC_CAP_WID_RST    8'h24
`define VMC_PTR_NONE       64'hffff_ffff_ffff_ffff

// ----------------------------------------
// instruction kinds, outcomes, error numbers
// ----------------------------------------
`define VMC_KIND_ENTER  2'h0
`define VMC_KIND_LEAVE  2'h1
`define VMC_KIND_WRITE  2'h2
`define VMC_RES_NONE    4'h0
`define VMC_RES_UD      4'h1
`define VMC_RES_EXIT    4'h2
`define VMC_RES_GP      4'h3
`define VMC_RES_SS      4'h4
`define VMC_RES_PF      4'h5
`define VMC_RES_FINV    4'h6
`define VMC_RES_FVAL    4'h7
`define VMC_RES_SUCC    4'h8
`define VMC_ERR_ENTER   8'h0f
`define VMC_ERR_LEAVE   8'h17

`endif

// ==== src/vmc_opnd_chk.v ====
// memory operand fault classifier for enter and structure-write
`timescale 1ns/1ns
`default_nettype none
`include "vmc_map.vh"
module vmc_opnd_chk (
  input  wire       mode64,
  input  wire       uses_ss,
  input  wire       noncanon,
  input  wire       limit_fail,
  input  wire       seg_unusable,
  input  wire       exec_only,
  input  wire       page_fail,
  output reg  [3:0] fault_code
);

  // ----------------------------------------
  // segment checks precede the page walk
  // ----------------------------------------
  always @* begin
    fault_code = `VMC_RES_NONE;
    if (mode64 && noncanon) begin
      fault_code = uses_ss ? `VMC_RES_SS : `VMC_RES_GP; // RL19
    end else if (!mode64 && uses_ss && (limit_fail || seg_unusable)) begin
      fault_code = `VMC_RES_SS; // RL18
    end else if (!mode64 && !uses_ss && (limit_fail || seg_unusable || exec_only)) begin
      fault_code = `VMC_RES_GP; // RL17
    end else if (page_fail) begin
      fault_code = `VMC_RES_PF; // RL18
    end
  end

endmodule
`default_nettype wire

// ==== src/vmc_top.v ====
// virtualization enter/leave checker with apb register file
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "vmc_map.vh"
module vmc_top #(
  parameter [30:0] REV_ID = 31'h0000_0001
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output wire [31:0] prdata,
  output wire        pslverr,
  input  wire        instr_valid,
  input  wire [1:0]  instr_kind,
  input  wire        operand_is_reg,
  input  wire        protected_mode_enable,
  input  wire        virt_enable_ctrl_bit,
  input  wire        v86_flag,
  input  wire        long_mode_active,
  input  wire        cs_long,
  input  wire [1:0]  current_privilege_level,
  input  wire        cr_values_ok,
  input  wire        guest_mode,
  input  wire        dual_monitor_active,
  input  wire        safer_mode_operation,
  input  wire [63:0] region_addr,
  input  wire [31:0] region_rev_word,
  input  wire        opnd_uses_ss,
  input  wire        opnd_noncanon,
  input  wire        opnd_limit_fail,
  input  wire        opnd_seg_unusable,
  input  wire        opnd_exec_only,
  input  wire        opnd_page_fail,
  input  wire        addr_bit20_mask_pin,
  output wire        res_valid,
  output wire [3:0]  res_code,
  output wire [7:0]  res_err_num,
  output wire        monitor_clear,
  output wire        virt_op_active,
  output wire        init_blocked,
  output wire        sys_mgmt_interrupt_blocked,
  output wire        addr_bit20_mask_en,
  output wire [63:0] cur_struct_ptr
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function bad_mode;
    input pe;
    input vm;
    input lma;
    input csl;
    begin
      bad_mode = !pe || vm || (lma && !csl);
    end
  endfunction

  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      lane_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          lane_merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  function beyond_width;
    input [63:0] a;
    input [7:0]  w;
    begin
      beyond_width = (w < 8'd64) && ((a >> w) != 64'h0);
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg        a20_s1_q;
  reg        a20_s2_q;
  reg [2:0]  feat_q;
  reg [2:0]  monctl_q;
  reg [7:0]  cap_wid_q;
  reg        cap_narrow_q;
  reg [30:0] rev_q;
  reg        virt_op_q;
  reg        init_blk_q;
  reg        smi_blk_q;
  reg        a20_en_q;
  reg [63:0] ptr_q;
  reg [63:0] rgn_q;
  reg        res_valid_q;
  reg [3:0]  res_code_q;
  reg [7:0]  res_err_q;
  reg        mon_clr_q;
  reg [31:0] prdata_q;
  reg        pslverr_q;

  reg [3:0]  code_d;
  reg [7:0]  err_d;
  reg        enter_d;
  reg        leave_d;
  reg [31:0] rd_mux;
  reg        rd_bad;

  wire [3:0] opnd_fault;
  wire       mode64    = long_mode_active && cs_long;
  wire       cpl_nz    = current_privilege_level != 2'h0;
  wire       in_addr_bit20_mask   = a20_en_q && a20_s2_q;
  wire       common_ud = bad_mode(protected_mode_enable, v86_flag, long_mode_active, cs_long);
  wire       fire      = clk_en && instr_valid;
  wire       wr_hit    = clk_en && psel && penable && pwrite;
  wire       setup     = clk_en && psel && !penable;
  wire       en_gp     = safer_mode_operation ? !feat_q[`VMC_FEAT_EN_SAFER]
                                              : !feat_q[`VMC_FEAT_EN_PLAIN];
  wire       rgn_bad   = (region_addr[11:0] != 12'h000)
                         || beyond_width(region_addr, cap_wid_q)
                         || (cap_narrow_q && (region_addr[63:32] != 32'h0));
  wire       rev_bad   = (region_rev_word[30:0] != rev_q) || region_rev_word[31];
  // merged words are cut back to each register's width on purpose
  wire [31:0] feat_merged = lane_merge({29'h0, feat_q}, pwdata, pstrb);
  wire [31:0] mon_merged  = lane_merge({29'h0, monctl_q}, pwdata, pstrb);
  wire [31:0] rev_merged  = lane_merge({1'b0, rev_q}, pwdata, pstrb);

  vmc_opnd_chk u_opnd (
    .mode64       (mode64),
    .uses_ss      (opnd_uses_ss),
    .noncanon     (opnd_noncanon),
    .limit_fail   (opnd_limit_fail),
    .seg_unusable (opnd_seg_unusable),
    .exec_only    (opnd_exec_only),
    .page_fail    (opnd_page_fail),
    .fault_code   (opnd_fault)
  );

  // ----------------------------------------
  // outcome decision, first match wins
  // ----------------------------------------
  always @* begin
    code_d  = `VMC_RES_NONE;
    err_d   = 8'h00;
    enter_d = 1'b0;
    leave_d = 1'b0;
    case (instr_kind) // RL21
      `VMC_KIND_ENTER: begin
        if (operand_is_reg || !virt_enable_ctrl_bit || common_ud) begin
          code_d = `VMC_RES_UD; // RL2
        end else if (!virt_op_q) begin
          if (cpl_nz || in_addr_bit20_mask || !cr_values_ok
              || !feat_q[`VMC_FEAT_LOCK] || en_gp) begin
            code_d = `VMC_RES_GP; // RL10
          end else if (opnd_fault != `VMC_RES_NONE) begin
            code_d = opnd_fault; // RL17 RL18 RL19
          end else if (rgn_bad) begin
            code_d = `VMC_RES_FINV; // RL11 RL12
          end else if (rev_bad) begin
            code_d = `VMC_RES_FINV; // RL13
          end else begin
            code_d  = `VMC_RES_SUCC; // RL14
            enter_d = 1'b1;
          end
        end else if (guest_mode) begin
          code_d = `VMC_RES_EXIT; // RL3
        end else if (cpl_nz) begin
          code_d = `VMC_RES_GP;
        end else begin
          code_d = `VMC_RES_FVAL; // RL15
          err_d  = `VMC_ERR_ENTER; // RL20
        end
      end
      `VMC_KIND_LEAVE: begin
        if (!virt_op_q || common_ud) begin
          code_d = `VMC_RES_UD; // RL1 RL16
        end else if (guest_mode) begin
          code_d = `VMC_RES_EXIT; // RL3
        end else if (cpl_nz) begin
          code_d = `VMC_RES_GP; // RL4
        end else if (dual_monitor_active) begin
          code_d = `VMC_RES_FVAL; // RL5
          err_d  = `VMC_ERR_LEAVE; // RL20
        end else begin
          code_d  = `VMC_RES_SUCC; // RL6
          leave_d = 1'b1;
        end
      end
      `VMC_KIND_WRITE: begin
        if (!virt_op_q || common_ud) begin
          code_d = `VMC_RES_UD; // RL16
        end else if (guest_mode) begin
          code_d = `VMC_RES_EXIT;
        end else if (cpl_nz) begin
          code_d = `VMC_RES_GP;
        end else if (ptr_q == `VMC_PTR_NONE) begin
          code_d = `VMC_RES_FINV;
        end else if (opnd_fault != `VMC_RES_NONE) begin
          code_d = opnd_fault; // RL17 RL18 RL19
        end else begin
          code_d = `VMC_RES_SUCC;
        end
      end
      default: begin
        code_d = `VMC_RES_UD;
      end
    endcase
  end

  // ----------------------------------------
  // mode state and side effects
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a20_s1_q    <= 1'b0;
      a20_s2_q    <= 1'b0;
      virt_op_q   <= 1'b0;
      init_blk_q  <= 1'b0;
      smi_blk_q   <= 1'b0;
      a20_en_q    <= 1'b1;
      ptr_q       <= `VMC_PTR_NONE;
      rgn_q       <= 64'h0;
      res_valid_q <= 1'b0;
      res_code_q  <= `VMC_RES_NONE;
      res_err_q   <= 8'h00;
      mon_clr_q   <= 1'b0;
    end else if (clk_en) begin
      // the mask pin is asynchronous to the core
      a20_s1_q    <= addr_bit20_mask_pin;
      a20_s2_q    <= a20_s1_q;
      res_valid_q <= instr_valid;
      mon_clr_q   <= instr_valid && (enter_d || leave_d); // RL6 RL14
      if (instr_valid) begin
        res_code_q <= code_d;
        res_err_q  <= err_d;
      end
      if (fire && enter_d) begin
        virt_op_q  <= 1'b1; // RL14
        init_blk_q <= 1'b1;
        a20_en_q   <= 1'b0;
        ptr_q      <= `VMC_PTR_NONE;
        rgn_q      <= region_addr; // RL9
      end
      if (fire && leave_d) begin
        virt_op_q  <= 1'b0; // RL6
        init_blk_q <= 1'b0;
        if (!safer_mode_operation) begin
          a20_en_q <= 1'b1; // RL8
        end
      end
      // software block request wins over a same-cycle unblock
      if (wr_hit && paddr == `VMC_OFF_CTRL && pstrb[0]
          && pwdata[`VMC_CTRL_SMI_SET]) begin
        smi_blk_q <= 1'b1;
      end else if (fire && leave_d && !monctl_q[`VMC_MONCTL_KEEP]) begin
        smi_blk_q <= 1'b0; // RL7
      end
    end
  end

  // ----------------------------------------
  // apb register file
  // ----------------------------------------
  always @* begin
    rd_mux = 32'h0;
    rd_bad = 1'b0;
    case (paddr)
      `VMC_OFF_CTRL:   rd_mux = {31'h0, smi_blk_q};
      `VMC_OFF_FEAT:   rd_mux = {29'h0, feat_q};
      `VMC_OFF_MONCTL: rd_mux = {29'h0, monctl_q};
      `VMC_OFF_CAP:    rd_mux = {15'h0, cap_narrow_q, 8'h0, cap_wid_q};
      `VMC_OFF_REV:    rd_mux = {1'b0, rev_q};
      `VMC_OFF_STATUS: rd_mux = {16'h0, res_err_q, a20_en_q, smi_blk_q,
                                 init_blk_q, virt_op_q, res_code_q};
      `VMC_OFF_PTR_LO: rd_mux = ptr_q[31:0];
      `VMC_OFF_PTR_HI: rd_mux = ptr_q[63:32];
      `VMC_OFF_RGN_LO: rd_mux = rgn_q[31:0];
      `VMC_OFF_RGN_HI: rd_mux = rgn_q[63:32];
      default:         rd_bad = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feat_q       <= `VMC_FEAT_RST;
      monctl_q     <= `VMC_MONCTL_RST;
      cap_wid_q    <= `VMC_CAP_WID_RST;
      cap_narrow_q <= 1'b0;
      rev_q        <= 31'h0;
      prdata_q     <= 32'h0;
      pslverr_q    <= 1'b0;
    end else if (clk_en) begin
      if (setup) begin
        // read data are captured in setup so the access phase answers at once
        prdata_q  <= pwrite ? 32'h0 : rd_mux;
        pslverr_q <= rd_bad || (pwrite && paddr >= `VMC_OFF_STATUS);
      end
      if (wr_hit) begin
        case (paddr)
          `VMC_OFF_FEAT:   feat_q   <= feat_merged[2:0];
          `VMC_OFF_MONCTL: monctl_q <= mon_merged[2:0];
          `VMC_OFF_CAP: begin
            if (pstrb[0]) begin
              cap_wid_q <= pwdata[7:0];
            end
            if (pstrb[2]) begin
              cap_narrow_q <= pwdata[`VMC_CAP_NARROW];
            end
          end
          `VMC_OFF_REV:    rev_q    <= rev_merged[30:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pready                     = clk_en;
  assign prdata                     = prdata_q;
  assign pslverr                    = pslverr_q;
  assign res_valid                  = res_valid_q;
  assign res_code                   = res_code_q;
  assign res_err_num                = res_err_q;
  assign monitor_clear              = mon_clr_q;
  assign virt_op_active             = virt_op_q;
  assign init_blocked               = init_blk_q;
  assign sys_mgmt_interrupt_blocked = smi_blk_q;
  assign addr_bit20_mask_en         = a20_en_q;
  assign cur_struct_ptr             = ptr_q;

endmodule
`default_nettype wire

// ==== verification/vmc_sw_model.sv ====
// instruction issuer standing in for privileged software
`timescale 1ns/1ns
`default_nettype none
module vmc_sw_model (
  input  wire logic        pclk,
  output logic             instr_valid,
  output logic [1:0]       instr_kind,
  output logic [17:0]      flags,
  output logic [63:0]      region_addr,
  output logic [31:0]      region_rev_word
);
  initial begin
    instr_valid = 1'b0;
    instr_kind = 2'h0;
    flags = 18'h0;
    region_addr = 64'h0;
    region_rev_word = 32'h0;
  end
  // operand is scrambled after the pulse so a stale value cannot pass
  task issue(input logic [1:0] k, input logic [17:0] f, input logic [63:0] a,
             input logic [31:0] r);
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr_kind <= k;
    flags <= f;
    region_addr <= a;
    region_rev_word <= r;
    @(posedge pclk);
    instr_valid <= 1'b0;
    region_addr <= ~a;
    region_rev_word <= ~r;
  endtask
endmodule
`default_nettype wire

// ==== verification/vmc_chk.sv ====
// outcome and side-effect assertions for the enter/leave checker
`timescale 1ns/1ns
`default_nettype none
`include "vmc_map.vh"
module vmc_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        instr_valid,
  input wire logic [1:0]  instr_kind,
  input wire logic        operand_is_reg,
  input wire logic        protected_mode_enable,
  input wire logic        v86_flag,
  input wire logic        long_mode_active,
  input wire logic        cs_long,
  input wire logic [1:0]  current_privilege_level,
  input wire logic        guest_mode,
  input wire logic        dual_monitor_active,
  input wire logic        res_valid,
  input wire logic [3:0]  res_code,
  input wire logic [7:0]  res_err_num,
  input wire logic        monitor_clear,
  input wire logic        virt_op_active,
  input wire logic        init_blocked,
  input wire logic        addr_bit20_mask_en,
  input wire logic [63:0] cur_struct_ptr
);
  // frozen cycles are invisible: every state and pulse holds while clk_en is low
  default clocking @(posedge pclk iff clk_en); endclocking
  default disable iff (!presetn);
  logic take;
  logic lv;
  logic mode_ok;
  assign take = instr_valid & clk_en;
  assign lv = take & (instr_kind == `VMC_KIND_LEAVE);
  assign mode_ok = protected_mode_enable & !v86_flag & !(long_mode_active & !cs_long);
  chk_result_next: assert property (take |=> res_valid)
    else $error("no result after instruction");
  chk_no_spurious: assert property (!take |=> !res_valid)
    else $error("result without instruction");
  chk_enter_reg: assert property (take && instr_kind == `VMC_KIND_ENTER && operand_is_reg
    |=> res_code == `VMC_RES_UD) else $error("register operand not refused");
  chk_leave_out: assert property (lv && !virt_op_active
    |=> res_code == `VMC_RES_UD && !virt_op_active) else $error("leave outside not refused");
  chk_guest_exit: assert property (lv && mode_ok && virt_op_active && guest_mode
    |=> res_code == `VMC_RES_EXIT && virt_op_active) else $error("guest leave not exited");
  chk_leave_priv: assert property (lv && mode_ok && virt_op_active && !guest_mode
    && current_privilege_level != 2'h0 |=> res_code == `VMC_RES_GP && res_err_num == 8'h00)
    else $error("leave privilege fault wrong");
  chk_dual_fail: assert property (lv && mode_ok && virt_op_active && !guest_mode
    && current_privilege_level == 2'h0 && dual_monitor_active
    |=> res_code == `VMC_RES_FVAL && res_err_num == `VMC_ERR_LEAVE && virt_op_active)
    else $error("dual monitor leave wrong");
  chk_clear_succ: assert property (monitor_clear |-> res_valid && res_code == `VMC_RES_SUCC)
    else $error("monitor clear without success");
  chk_enter_state: assert property (monitor_clear && virt_op_active
    |-> init_blocked && !addr_bit20_mask_en && cur_struct_ptr == `VMC_PTR_NONE)
    else $error("enter side effects wrong");
  chk_leave_state: assert property (monitor_clear && !virt_op_active
    |-> !init_blocked && $past(virt_op_active)) else $error("leave side effects wrong");
  chk_err_zero: assert property (res_valid && res_code != `VMC_RES_FVAL
    |-> res_err_num == 8'h00) else $error("error number without valid failure");
  cover property (monitor_clear && virt_op_active);
  cover property (monitor_clear && !virt_op_active);
  cover property (res_valid && res_code == `VMC_RES_SS);
endmodule
bind vmc_top vmc_chk u_chk (.*);
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the enter/leave checker with a reference model
`timescale 1ns/1ns
`default_nettype none
`include "vmc_map.vh"
module tb;
  localparam logic [30:0] REVV = 31'h0000_005a;
  logic pclk, presetn, clk_en, psel, penable, pwrite, addr_bit20_mask_pin, perr, e_clr, m_nar;
  logic [7:0]  paddr, e_err;
  logic [31:0] pwdata, rd, r, x, y;
  logic [3:0]  pstrb, e_code;
  logic [2:0]  m_feat, m_mon;
  logic [63:0] m_ptr, a;
  logic [17:0] f;
  logic [1:0]  k;
  wire pready, pslverr, res_valid, monitor_clear, virt_op_active, init_blocked, instr_valid;
  wire sys_mgmt_interrupt_blocked, addr_bit20_mask_en;
  wire [31:0] prdata, region_rev_word;
  wire [3:0]  res_code;
  wire [7:0]  res_err_num;
  wire [63:0] cur_struct_ptr, region_addr;
  wire [1:0]  instr_kind;
  wire [17:0] flg;
  wire operand_is_reg = flg[0], protected_mode_enable = flg[1], virt_enable_ctrl_bit = flg[2];
  wire v86_flag = flg[3], long_mode_active = flg[4], cs_long = flg[5], cr_values_ok = flg[8];
  wire [1:0] current_privilege_level = flg[7:6];
  wire guest_mode = flg[9], dual_monitor_active = flg[10], safer_mode_operation = flg[11];
  wire opnd_uses_ss = flg[12], opnd_noncanon = flg[13], opnd_limit_fail = flg[14];
  wire opnd_seg_unusable = flg[15], opnd_exec_only = flg[16], opnd_page_fail = flg[17];
  integer fail_count = 0, n_checks = 0, seed = 32'h3274, i, m_virt, m_init, m_smi, m_a20;

  vmc_top DUT (.*);
  vmc_sw_model sw (.pclk(pclk), .instr_valid(instr_valid), .instr_kind(instr_kind),
                   .flags(flg), .region_addr(region_addr), .region_rev_word(region_rev_word));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task chk(input string n, input logic [63:0] s, input logic [63:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    integer n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      stop_test;
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rchk(input logic [7:0] ad, input logic [31:0] e, input logic ee);
    apb(1'b0, ad, 32'h0);
    chk("rdata", rd, e);
    chk("pslverr", perr, ee);
  endtask

  // ----------------------------------------
  // reference model, first matching outcome only
  // ----------------------------------------
  task predict;
    logic bad;
    bad = !f[1] || f[3] || (f[4] && !f[5]);
    e_err = 8'h0;
    e_clr = 1'b0;
    if (k == 2'h3) e_code = `VMC_RES_UD;
    else if (k == 2'h0 && (f[0] || !f[2] || bad)) e_code = `VMC_RES_UD;
    else if (k != 2'h0 && (m_virt == 0 || bad)) e_code = `VMC_RES_UD;
    else if (k == 2'h0 && m_virt == 0) begin
      if (f[7:6] != 0 || (addr_bit20_mask_pin && m_a20 != 0) || !f[8] || !m_feat[0]
          || !(f[11] ? m_feat[1] : m_feat[2])) e_code = `VMC_RES_GP;
      else if ((f[4] && f[13]) || (!f[4] && (f[14] || f[15])))
        e_code = f[12] ? `VMC_RES_SS : `VMC_RES_GP;
      else if (f[16] && !f[4]) e_code = `VMC_RES_GP;
      else if (f[17]) e_code = `VMC_RES_PF;
      else if (a[11:0] != 0 || a[63:36] != 0 || (m_nar && a[63:32] != 0))
        e_code = `VMC_RES_FINV;
      else if (r[31] || r[30:0] != REVV) e_code = `VMC_RES_FINV;
      else begin
        e_code = `VMC_RES_SUCC;
        m_virt = 1;
        m_init = 1;
        m_a20 = 0;
        m_ptr = `VMC_PTR_NONE;
        e_clr = 1'b1;
      end
    end
    else if (f[9]) e_code = `VMC_RES_EXIT;
    else if (f[7:6] != 0) e_code = `VMC_RES_GP;
    else if (k == 2'h0) begin
      e_code = `VMC_RES_FVAL;
      e_err = `VMC_ERR_ENTER;
    end
    else if (k == 2'h2) e_code = `VMC_RES_FINV;
    else if (f[10]) begin
      e_code = `VMC_RES_FVAL;
      e_err = `VMC_ERR_LEAVE;
    end
    else begin
      e_code = `VMC_RES_SUCC;
      m_virt = 0;
      m_init = 0;
      if (!m_mon[2]) m_smi = 0;
      if (!f[11]) m_a20 = 1;
      e_clr = 1'b1;
    end
  endtask

  initial begin
    #1000000;
    fail_count++;
    stop_test;
  end

  initial begin
    {presetn, psel, penable, pwrite, addr_bit20_mask_pin, m_nar} = 6'h0;
    clk_en = 1'b1;
    paddr = 8'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    {m_virt, m_init, m_smi, m_a20} = {32'd0, 32'd0, 32'd0, 32'd1};
    {m_feat, m_mon, e_code, e_err} = 18'h0;
    m_ptr = `VMC_PTR_NONE;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`VMC_OFF_FEAT, 32'h0, 1'b0);
    rchk(`VMC_OFF_CAP, 32'h24, 1'b0);
    rchk(`VMC_OFF_PTR_HI, 32'hffff_ffff, 1'b0);
    rchk(8'h28, 32'h0, 1'b1);
    apb(1'b1, `VMC_OFF_STATUS, 32'hf);
    chk("ro_write", perr, 1'b1);
    apb(1'b1, `VMC_OFF_REV, {1'b0, REVV});
    for (i = 0; i < 700; i++) begin
      x = $random(seed);
      y = $random(seed);
      if (i == 0 || x[3:0] == 0) begin
        m_feat = (x[5:4] == 0) ? x[8:6] : 3'h7;
        m_mon = x[11:9];
        m_nar = x[12];
        apb(1'b1, `VMC_OFF_FEAT, {29'h0, m_feat});
        apb(1'b1, `VMC_OFF_MONCTL, {29'h0, m_mon});
        apb(1'b1, `VMC_OFF_CAP, {15'h0, m_nar, 16'h0024});
      end
      if (x[16:13] == 0) begin
        apb(1'b1, `VMC_OFF_CTRL, 32'h1);
        m_smi = 1;
      end
      addr_bit20_mask_pin <= (x[19:17] == 0);
      rchk(`VMC_OFF_STATUS, {16'h0, e_err, m_a20[0], m_smi[0], m_init[0], m_virt[0], e_code},
           1'b0);
      f = 18'h0;
      f[0] = x[22:20] == 0;
      f[1] = x[25:23] != 0;
      f[2] = x[28:26] != 0;
      f[3] = x[31:29] == 0;
      f[4] = y[11];
      f[5] = y[11] ? (y[14:12] != 0) : y[12];
      f[7:6] = (y[17:15] == 0) ? y[19:18] : 2'h0;
      f[8] = y[22:20] != 0;
      f[9] = y[24:23] == 0;
      f[10] = y[26:25] == 0;
      f[11] = y[27];
      f[12] = y[28];
      case (y[2:0])
        3'h0: f[13] = f[4];
        3'h1: f[14] = !f[4];
        3'h2: f[15] = !f[4];
        3'h3: {f[16], f[12]} = 2'b10;
        3'h4: f[17] = 1'b1;
        default: ;
      endcase
      k = y[4:3];
      a = {$random(seed), $random(seed)};
      if (y[6:5] != 0) a[11:0] = 12'h0;
      if (y[6]) a[63:36] = 28'h0;
      if (y[7] && y[6]) a[35:32] = 4'h0;
      r = (y[10:8] == 0) ? $random(seed) : {1'b0, REVV};
      predict;
      sw.issue(k, f, a, r);
      #1;
      chk("res_valid", res_valid, 1'b1);
      chk("res_code", res_code, e_code);
      chk("err_num", res_err_num, e_err);
      chk("mon_clear", monitor_clear, e_clr);
      chk("virt_op", virt_op_active, m_virt);
      chk("init_blk", init_blocked, m_init);
      chk("smi_blk", sys_mgmt_interrupt_blocked, m_smi);
      chk("a20_en", addr_bit20_mask_en, m_a20);
      chk("ptr", cur_struct_ptr, m_ptr);
      if (y[31:29] == 0) begin
        clk_en <= 1'b0;
        repeat (3) @(posedge pclk);
        #1;
        chk("pready_off", pready, 1'b0);
        chk("held_valid", res_valid, 1'b1);
        chk("held_clear", monitor_clear, e_clr);
        chk("held_virt", virt_op_active, m_virt);
        clk_en <= 1'b1;
      end
    end
    stop_test;
  end
endmodule
`default_nettype wire
